//--- ais_host.sv
/* host model: config writes and power-down pin.
   assumes the bench calls its tasks in turn. */
`timescale 1ns/1ns
module ais_host
  import ais_pkg::*;
(
  input wire logic i_clk_sys,
  output ais_wr_type o_wr,
  output logic o_power_down_pin
);
  initial begin
    o_wr = '0;
    o_power_down_pin = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1 o_wr = '{1'b1, a, d};
  endtask
  // idle port, valid low; fields invert each cycle, so the last write's values return every second idle cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      #1 o_wr = '{1'b0, ~o_wr.addr, ~o_wr.data};
    end
  endtask
  task automatic pin(input logic v);
    @(posedge i_clk_sys);
    #1 o_power_down_pin = v;
  endtask
  task automatic dreset(input int gap);
    wr(AIS_ADDR_PMODE, 8'h03);
    idle(gap);
    wr(AIS_ADDR_PMODE, 8'h00);
    idle(1);
  endtask
endmodule

//--- ais_interval_counter.sv
/*
  interval counter: counts sample clocks from a start pulse up to a limit
  and pulses done at the terminal count. assumes the limit is steady
  while a count runs and is at least one.
*/
`timescale 1ns/1ns
module ais_interval_counter
  import ais_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  input wire logic i_start,
  input wire logic [AIS_CNT_W-1:0] i_limit,
  // status
  output logic o_busy,
  output logic o_done
);

  typedef struct packed {
    logic [AIS_CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } ais_cnt_state_type;

  ais_cnt_state_type s_q;
  ais_cnt_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (i_start) begin
      // restart wins over a running count
      s_d.cnt = '0;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (s_q.cnt == i_limit - 1'b1) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1; // R14
      end else begin
        s_d.cnt = s_q.cnt + 1'b1; // R14
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = s_q.busy;
  assign o_done = s_q.done;

endmodule

//--- ais_pkg.sv
/*
  constants, field layouts and carrier types for the converter start-up
  and digital-reset sequencer. assumes nothing beyond a SystemVerilog tool.
*/
package ais_pkg;

  // configuration write offsets
  localparam logic [7:0] AIS_ADDR_PMODE = 8'h08;
  localparam logic [7:0] AIS_ADDR_OMODE = 8'h14;

  // power-mode field
  localparam int AIS_PMODE_LSB = 0;
  localparam int AIS_PMODE_W = 2;
  localparam int AIS_PINFN_BIT = 5;
  localparam logic [1:0] AIS_PMODE_NORMAL = 2'h0;
  localparam logic [1:0] AIS_PMODE_PDOWN = 2'h1;
  localparam logic [1:0] AIS_PMODE_STANDBY = 2'h2;
  localparam logic [1:0] AIS_PMODE_DRESET = 2'h3;

  // output-mode field
  localparam int AIS_OTYPE_LSB = 6;
  localparam int AIS_OTYPE_W = 2;
  localparam int AIS_OTYPE_LVDS_BIT = 1;
  localparam logic [1:0] AIS_OTYPE_CMOS = 2'h0;

  // sequencing counter width in bits, and counts in sample clock cycles
  localparam int AIS_CNT_W = 22;
  localparam int AIS_RECOVER_CYCLES = 2900000;
  localparam logic [AIS_CNT_W-1:0] AIS_INIT_CYCLES = 22'h000400;

  localparam int AIS_DATA_W = 12;

  typedef enum logic [2:0] {
    AIS_ST_INIT = 3'h0,
    AIS_ST_RUN = 3'h1,
    AIS_ST_DRST = 3'h3,
    AIS_ST_RECOV = 3'h2,
    AIS_ST_FAULT = 3'h6
  } ais_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ais_wr_type;

  typedef struct packed {
    logic [AIS_DATA_W-1:0] chan_b;
    logic [AIS_DATA_W-1:0] chan_a;
  } ais_sample_type;

endpackage

//--- ais_seq_asserts.sv
/* checker on ais_sequencer ports.
   assumes bind to the top module. */
`timescale 1ns/1ns
module ais_seq_asserts
  import ais_pkg::*;
#(parameter int RECOVER_CYCLES = 20) (
  // clock, reset, inputs
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_power_down_pin,
  input wire ais_wr_type i_wr,
  // outputs
  input wire logic o_out_en,
  input wire logic o_lvds_mode,
  input wire logic o_dp_clk_en,
  input wire logic o_dp_rst,
  input wire ais_sample_type o_data,
  input wire logic o_ready,
  input wire logic o_init_fault
);
  localparam int RC2 = RECOVER_CYCLES + 2;
  logic pw, ow, dr, rl;
  assign pw = i_wr.valid && i_wr.addr == AIS_ADDR_PMODE;
  assign ow = i_wr.valid && i_wr.addr == AIS_ADDR_OMODE;
  assign dr = pw && i_wr.data[1:0] == AIS_PMODE_DRESET;
  // release write while held in digital reset
  assign rl = pw && i_wr.data[1:0] == AIS_PMODE_NORMAL && o_dp_rst && o_out_en;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_cmos; !o_lvds_mode && !ow |=> !o_lvds_mode; endproperty
  a_cmos: assert property (p_cmos) else $error("lvds");
  property p_lvds; ow |=> o_lvds_mode == $past(i_wr.data[7]); endproperty
  a_lvds: assert property (p_lvds) else $error("mode");
  property p_pin; i_power_down_pin |=> !o_out_en; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_dr; dr |=> o_dp_rst && !o_dp_clk_en && !o_ready; endproperty
  a_dr: assert property (p_dr) else $error("dreset");
  property p_en; o_dp_rst && o_out_en && !i_power_down_pin && !pw |=> o_out_en; endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_rec; rl |-> ##RC2 $rose(o_ready); endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_zero; !o_ready |-> o_data == '0; endproperty
  a_zero: assert property (p_zero) else $error("data");
  property p_hold; o_init_fault && !dr |=> o_init_fault; endproperty
  a_hold: assert property (p_hold) else $error("fault");
  c_rl: cover property (rl);
  c_flt: cover property ($rose(o_init_fault));
  c_lvds: cover property ($rose(o_lvds_mode));
endmodule

bind ais_sequencer ais_seq_asserts #(.RECOVER_CYCLES(RECOVER_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_power_down_pin(i_power_down_pin),
  .i_wr(i_wr),
  .o_out_en(o_out_en),
  .o_lvds_mode(o_lvds_mode),
  .o_dp_clk_en(o_dp_clk_en),
  .o_dp_rst(o_dp_rst),
  .o_data(o_data),
  .o_ready(o_ready),
  .o_init_fault(o_init_fault)
);

//--- ais_sequencer.sv
/*
  digital-side start-up and recovery sequencer of a dual converter.
  runs on the sample clock; configuration writes arrive already decoded
  from the serial port, one write per valid cycle.
  assumes i_clk_stable comes from a clock monitor beside the block.
*/
// Notes on behaviour
// [R1] outputs come up in single-ended CMOS mode before any configuration write
// [R2] host selects LVDS output through the output-mode write after power-up
// [R3] power-down pin high keeps outputs disabled; pin low enables them
// [R4] power-on runs an init sequence needing a stable sample clock
// [R5] unstable clock at init leaves undefined state until a digital reset
// [R6] host resets again if external references were unstable at power-up
// [R7] host resets after clock interruption or a sample rate change
// [R8] digital reset is write 0x03 then write 0x00 to the power-mode offset
// [R9] release write may follow the assert write back to back
// [R10] normal output resumes only after 2.9e6 sample clocks from release
// [R11] data outputs are all zero until recovery completes
// [R12] host should keep the serial port idle during critical sampling
// [R13] power mode 11 gates and resets the data path, outputs stay enabled
// [R14] recovery uses a counter started at release, done at terminal count
`timescale 1ns/1ns
module ais_sequencer
  import ais_pkg::*;
#(
  parameter int RECOVER_CYCLES = AIS_RECOVER_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // board-level inputs
  input wire logic i_power_down_pin,
  input wire logic i_clk_stable,
  // decoded configuration writes
  input wire ais_wr_type i_wr,
  // raw conversion samples
  input wire ais_sample_type i_sample,
  // output driver control
  output logic o_out_en,
  output logic o_lvds_mode,
  // data path control
  output logic o_dp_clk_en,
  output logic o_dp_rst,
  // converted data
  output ais_sample_type o_data,
  // status
  output logic o_ready,
  output logic o_init_fault
);

  typedef struct packed {
    ais_state_type state;
    logic kicked;
    logic [AIS_PMODE_W-1:0] pmode;
    logic [AIS_OTYPE_W-1:0] otype;
    logic out_en;
    logic lvds;
    logic dp_clk_en;
    logic dp_rst;
    ais_sample_type data;
    logic ready;
    logic fault;
  } ais_top_state_type;

  typedef struct packed {
    logic drv_on;
    logic clk_on;
    logic hold_rst;
  } ais_pm_effect_type;

  localparam logic [AIS_CNT_W-1:0] RECOVER_LIMIT = AIS_CNT_W'(RECOVER_CYCLES);

  ais_top_state_type s_q;
  ais_top_state_type s_d;
  logic cnt_start;
  logic [AIS_CNT_W-1:0] cnt_limit;
  logic cnt_done;
  logic wr_pmode;
  logic wr_omode;
  ais_pm_effect_type pm_fx;

  ais_interval_counter u_interval (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(cnt_start),
    .i_limit(cnt_limit),
    .o_busy(),
    .o_done(cnt_done)
  );

  // the limit follows the phase that owns the running count
  assign cnt_limit = (s_q.state == AIS_ST_INIT) ? AIS_INIT_CYCLES : RECOVER_LIMIT;

  // decoded write strobes, one per offset that this block keeps
  assign wr_pmode = i_wr.valid && (i_wr.addr == AIS_ADDR_PMODE);
  assign wr_omode = i_wr.valid && (i_wr.addr == AIS_ADDR_OMODE);

  // drivers, data path clock and data path reset for each power mode
  function automatic ais_pm_effect_type pm_effect(input logic [AIS_PMODE_W-1:0] mode);
    ais_pm_effect_type eff;
    eff = '0;
    case (mode)
      AIS_PMODE_NORMAL: begin
        eff.drv_on = 1'b1;
        eff.clk_on = 1'b1;
        eff.hold_rst = 1'b0;
      end
      AIS_PMODE_PDOWN: begin
        eff.drv_on = 1'b0;
        eff.clk_on = 1'b0;
        eff.hold_rst = 1'b1;
      end
      AIS_PMODE_STANDBY: begin
        eff.drv_on = 1'b0;
        eff.clk_on = 1'b0;
        eff.hold_rst = 1'b0;
      end
      default: begin
        // digital reset keeps the drivers on while the path is held
        eff.drv_on = 1'b1; // R13
        eff.clk_on = 1'b0; // R13
        eff.hold_rst = 1'b1; // R13
      end
    endcase
    return eff;
  endfunction

  always_comb begin
    s_d = s_q;
    cnt_start = 1'b0;
    pm_fx = '0;

    // configuration writes update fields in the cycle they arrive
    if (wr_pmode) begin
      s_d.pmode = i_wr.data[AIS_PMODE_LSB +: AIS_PMODE_W]; // R8
    end else if (wr_omode) begin
      s_d.otype = i_wr.data[AIS_OTYPE_LSB +: AIS_OTYPE_W];
    end

    case (s_q.state)
      AIS_ST_INIT: begin
        // one start pulse, then watch the clock while the interval runs
        if (!s_q.kicked) begin
          cnt_start = 1'b1; // R4
          s_d.kicked = 1'b1;
        end else if (!i_clk_stable) begin
          s_d.state = AIS_ST_FAULT; // R5
        end else if (cnt_done) begin
          s_d.state = AIS_ST_RUN; // R4
        end
      end
      AIS_ST_DRST: begin
        if (s_d.pmode != AIS_PMODE_DRESET) begin
          // release may come in the very next write
          s_d.state = AIS_ST_RECOV; // R9
          cnt_start = 1'b1; // R14
        end
      end
      AIS_ST_RECOV: begin
        // zeros out until the counter reports done
        if (cnt_done) begin
          s_d.state = AIS_ST_RUN; // R10
        end
      end
      AIS_ST_RUN: begin
        // stays here until a reset write arrives
        s_d.state = AIS_ST_RUN;
      end
      AIS_ST_FAULT: begin
        // undefined start: only a digital reset leaves this state
        s_d.state = AIS_ST_FAULT; // R5
      end
      default: begin
        s_d.state = AIS_ST_INIT;
      end
    endcase

    // a reset write takes over from any state, fault included
    if (s_d.pmode == AIS_PMODE_DRESET) begin
      s_d.state = AIS_ST_DRST; // R5
    end

    // pin and power modes 01/10 turn the drivers off; 11 keeps them on
    pm_fx = pm_effect(s_d.pmode);
    s_d.out_en = !i_power_down_pin && pm_fx.drv_on; // R3
    s_d.lvds = s_d.otype[AIS_OTYPE_LVDS_BIT]; // R1
    s_d.dp_clk_en = pm_fx.clk_on && (s_d.state != AIS_ST_DRST); // R13
    s_d.dp_rst = pm_fx.hold_rst || (s_d.state == AIS_ST_DRST); // R13
    s_d.ready = s_d.state == AIS_ST_RUN;
    s_d.fault = s_d.state == AIS_ST_FAULT;
    if (s_d.ready && s_d.pmode == AIS_PMODE_NORMAL) begin
      s_d.data = i_sample;
    end else begin
      s_d.data = '0; // R11
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q.state <= AIS_ST_INIT;
      s_q.kicked <= 1'b0;
      s_q.pmode <= AIS_PMODE_NORMAL;
      s_q.otype <= AIS_OTYPE_CMOS; // R1
      s_q.out_en <= 1'b0;
      s_q.lvds <= 1'b0;
      s_q.dp_clk_en <= 1'b0;
      s_q.dp_rst <= 1'b1;
      s_q.data <= '0;
      s_q.ready <= 1'b0;
      s_q.fault <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_out_en = s_q.out_en;
  assign o_lvds_mode = s_q.lvds;
  assign o_dp_clk_en = s_q.dp_clk_en;
  assign o_dp_rst = s_q.dp_rst;
  assign o_data = s_q.data;
  assign o_ready = s_q.ready;
  assign o_init_fault = s_q.fault;

endmodule

//--- ais_sequencer_bench.sv
/* self-checking bench for ais_sequencer.
   assumes ais_host and the bound checker. */
`timescale 1ns/1ns
module ais_sequencer_bench
  import ais_pkg::*;
;
  localparam int RC = 20;
  logic i_clk_sys = 1'b0;
  logic i_rst;
  logic i_clk_stable;
  logic i_power_down_pin, o_out_en, o_lvds_mode;
  logic o_dp_clk_en, o_dp_rst, o_ready, o_init_fault;
  ais_wr_type i_wr;
  ais_sample_type i_sample, o_data, e, q[$];
  int n_errors = 0, n_tests = 0, seed = 41628, n;
  logic [31:0] r;
  always #5 i_clk_sys = ~i_clk_sys;
  ais_host u_host (.i_clk_sys(i_clk_sys), .o_wr(i_wr), .o_power_down_pin(i_power_down_pin));
  ais_sequencer #(.RECOVER_CYCLES(RC)) u_dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_power_down_pin(i_power_down_pin),
    .i_clk_stable(i_clk_stable),
    .i_wr(i_wr),
    .i_sample(i_sample),
    .o_out_en(o_out_en),
    .o_lvds_mode(o_lvds_mode),
    .o_dp_clk_en(o_dp_clk_en),
    .o_dp_rst(o_dp_rst),
    .o_data(o_data),
    .o_ready(o_ready),
    .o_init_fault(o_init_fault)
  );
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_rdy(output int k);
    k = 0;
    while (o_ready !== 1'b1 && k < 3000) begin
      @(posedge i_clk_sys);
      #1 k++;
    end
  endtask
  // samples noted as sent, compared one cycle later
  always @(posedge i_clk_sys) begin
    #1 r = $random(seed);
    i_sample = r[23:0];
    q.push_back(i_sample);
  end
  always @(negedge i_clk_sys) begin
    if (q.size() > 1) begin
      e = q.pop_front();
      if (o_ready === 1'b1) chk(o_data, e);
    end
  end
  initial begin
    i_rst = 1'b1;
    i_clk_stable = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    chk(o_dp_rst, 1'b1);
    #1 i_rst = 1'b0;
    u_host.idle(2);
    chk({o_lvds_mode, o_out_en}, 2'b00);
    wait_rdy(n);
    chk(o_ready, 1'b1);
    u_host.wr(AIS_ADDR_OMODE, 8'h80);
    u_host.idle(1);
    chk(o_lvds_mode, 1'b1);
    u_host.pin(1'b0);
    u_host.idle(1);
    chk(o_out_en, 1'b1);
    for (int g = 0; g < 6; g += 5) begin
      u_host.dreset(g);
      chk({o_out_en, o_dp_clk_en, o_ready}, 3'b110);
      wait_rdy(n);
      // edges from the release edge: the recovery count, then one registration
      chk(24'(n), 24'(RC + 1));
    end
    i_rst = 1'b1;
    i_clk_stable = 1'b0;
    u_host.idle(2);
    i_rst = 1'b0;
    u_host.idle(20);
    chk({o_init_fault, o_lvds_mode}, 2'b10);
    i_clk_stable = 1'b1;
    u_host.dreset(0);
    wait_rdy(n);
    chk(24'(n), 24'(RC + 1));
    chk({o_init_fault, o_ready}, 2'b01);
    test_done;
  end
  initial begin
    #300000;
    n_errors++;
    test_done;
  end
endmodule
